// ===== verilog/drc_regs.sv
// Dual receive control and equalizer test registers with port-select access steering
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - With lock mode 0 the lock output is high only while linked and the remote video-disabled flag is clear.
// - With lock mode 1 the lock output is high whenever linked to a serializer, video or not.
// - With raw back channel set the synchronised GPIO input goes to the back channel unfiltered.
// - Lane mode field 4:3 selects auto, forced two-lane, forced one-lane primary or one-lane secondary.
// - With port-1 select set, writes reach port-1 and shared registers and reads return port-1 and shared.
// - Port-0 select (bit 0, reset 1) makes writes reach port-0 and shared; reads return shared, and port-0 only while port-1 select is clear.
// - With both selects set, reads return the port-1 copies.
// - Accesses at 0x35 target the port-1 equalizer controls while port-1 select is set.
// - Equalizer restart is held as written; writing 0 then 1 restarts adaptation.
// - A restart restarts adaptation on both receive ports regardless of selection.
// - The floor start bit has effect only while floor enable is set.
// - When in effect, adaptation starts from a preset floor instead of zero.
// - The video-disabled flag comes from the remote serializer and means no active video.
// - The dual-link status follows the forward channel and is not locally writable.
module drc_regs
    import drc_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rstn,
    // Register access from the serial control slave (same clock)
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    output logic o_reg_rvalid,
    // Link status from the receive front end (same clock)
    input wire logic i_linked,
    input wire logic i_remote_video_disabled,
    input wire logic i_remote_dual_link,
    // Back channel GPIO pin and the two back-channel sources
    input wire logic i_backchannel_gpio_input,
    input wire logic i_backchannel_gpio_filtered,
    output logic o_backchannel_gpio,
    // Link and access control outputs
    output logic o_rx_lock,
    output logic [1:0] o_serial_input_lane_mode,
    output logic o_dual_link_status,
    output logic o_port0_access,
    output logic o_port1_access,
    // Equalizer controls, one bit per receive port
    output logic [1:0] o_eq_restart,
    output logic [1:0] o_eq_start_from_floor
);
    typedef struct packed {
        logic [7:0] dual_rx;
        logic [7:0] eq_port0;
        logic [7:0] eq_port1;
        logic [7:0] rdata;
        logic rvalid;
        logic rx_lock;
        logic bc_gpio;
        logic dual_link;
    } drc_st_t;
    drc_st_t state_reg;
    drc_st_t state_next;

    logic gpio_sync;
    logic [1:0] eq_restart_w;
    logic [1:0] eq_floor_w;
    logic restart_any;

    // Read mux shared by read data; port 1 copies win when both selects are set
    function automatic logic [7:0] drc_read(input logic [7:0] addr, input drc_st_t st);
        logic [7:0] val;
        val = 8'h00;
        if (addr == DRC_ADDR_DUAL_RX) begin
            val = st.dual_rx & DRC_DUAL_RX_WMASK;
        end else if (addr == DRC_ADDR_EQ_TEST) begin
            if (st.dual_rx[DRC_BIT_SECOND_PORT_ACCESS_SELECT]) begin
                val = st.eq_port1 & DRC_EQ_TEST_WMASK;
            end else if (st.dual_rx[DRC_BIT_PORT0_SEL]) begin
                val = st.eq_port0 & DRC_EQ_TEST_WMASK;
            end
        end
        return val;
    endfunction : drc_read

    // Pin passes two flip-flops before any logic reads it
    drc_sync2 #(
        .WIDTH(1)
    ) u_gpio_sync (
        .i_mclk(i_mclk),
        .i_rstn(i_rstn),
        .i_async(i_backchannel_gpio_input),
        .o_sync(gpio_sync)
    );

    // Restart is a shared action: either port copy restarts both ports
    assign restart_any = state_reg.eq_port0[DRC_BIT_EQ_RESTART] | state_reg.eq_port1[DRC_BIT_EQ_RESTART];

    // Per-port equalizer start logic
    drc_eq_ctl u_eq0 (
        .i_mclk(i_mclk),
        .i_rstn(i_rstn),
        .i_restart_level(restart_any),
        .i_floor_enable(state_reg.eq_port0[DRC_BIT_EQ_FLOOR_EN]),
        .i_floor_start(state_reg.eq_port0[DRC_BIT_EQ_FLOOR_START]),
        .o_restart_pulse(eq_restart_w[0]),
        .o_start_from_floor(eq_floor_w[0])
    );

    drc_eq_ctl u_eq1 (
        .i_mclk(i_mclk),
        .i_rstn(i_rstn),
        .i_restart_level(restart_any),
        .i_floor_enable(state_reg.eq_port1[DRC_BIT_EQ_FLOOR_EN]),
        .i_floor_start(state_reg.eq_port1[DRC_BIT_EQ_FLOOR_START]),
        .o_restart_pulse(eq_restart_w[1]),
        .o_start_from_floor(eq_floor_w[1])
    );

    // Next state: register writes, read capture and link indications
    always_comb begin
        state_next = state_reg;
        state_next.rvalid = 1'b0;
        if (i_reg_wr) begin
            if (i_reg_addr == DRC_ADDR_DUAL_RX) begin
                // Reserved bits dropped so they never steer anything
                state_next.dual_rx = i_reg_wdata & DRC_DUAL_RX_WMASK;
            end else if (i_reg_addr == DRC_ADDR_EQ_TEST) begin
                // Both selects set: writes reach both copies
                if (state_reg.dual_rx[DRC_BIT_SECOND_PORT_ACCESS_SELECT]) begin
                    state_next.eq_port1 = i_reg_wdata & DRC_EQ_TEST_WMASK;
                end
                if (state_reg.dual_rx[DRC_BIT_PORT0_SEL]) begin
                    state_next.eq_port0 = i_reg_wdata & DRC_EQ_TEST_WMASK;
                end
            end
        end
        if (i_reg_rd) begin
            state_next.rdata = drc_read(i_reg_addr, state_reg);
            state_next.rvalid = 1'b1;
        end
        // Lock qualification by the lock mode bit
        if (state_reg.dual_rx[DRC_BIT_LOCK_MODE]) begin
            state_next.rx_lock = i_linked;
        end else begin
            state_next.rx_lock = i_linked & ~i_remote_video_disabled;
        end
        // Raw mode bypasses the oversampling filter entirely
        state_next.bc_gpio = state_reg.dual_rx[DRC_BIT_RAW_BC] ? gpio_sync : i_backchannel_gpio_filtered;
        // Status follows the forward channel only; no write path exists
        state_next.dual_link = i_remote_dual_link;
    end

    // State register
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_reg.dual_rx <= DRC_DUAL_RX_RESET;
            state_reg.eq_port0 <= DRC_EQ_TEST_RESET;
            state_reg.eq_port1 <= DRC_EQ_TEST_RESET;
            state_reg.rdata <= 8'h00;
            state_reg.rvalid <= 1'b0;
            state_reg.rx_lock <= 1'b0;
            state_reg.bc_gpio <= 1'b0;
            state_reg.dual_link <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs straight from flip-flops
    assign o_reg_rdata = state_reg.rdata;
    assign o_reg_rvalid = state_reg.rvalid;
    assign o_rx_lock = state_reg.rx_lock;
    assign o_backchannel_gpio = state_reg.bc_gpio;
    assign o_serial_input_lane_mode = state_reg.dual_rx[DRC_LANE_MODE_LSB +: 2];
    assign o_dual_link_status = state_reg.dual_link;
    assign o_port0_access = state_reg.dual_rx[DRC_BIT_PORT0_SEL];
    // Host must drop this before reading port-0 copies
    assign o_port1_access = state_reg.dual_rx[DRC_BIT_SECOND_PORT_ACCESS_SELECT];
    assign o_eq_restart = eq_restart_w;
    assign o_eq_start_from_floor = eq_floor_w;
endmodule : drc_regs
`default_nettype wire

// ===== verilog/drc_pkg.sv
// Package: offsets, field positions and reset values of the dual receive control bank
package drc_pkg;
    localparam logic [7:0] DRC_ADDR_DUAL_RX = 8'h34;
    localparam logic [7:0] DRC_ADDR_EQ_TEST = 8'h35;
    // Dual receive control fields
    localparam int DRC_BIT_LOCK_MODE = 6;
    localparam int DRC_BIT_RAW_BC = 5;
    localparam int DRC_LANE_MODE_LSB = 3;
    localparam int DRC_BIT_SECOND_PORT_ACCESS_SELECT = 1;
    localparam int DRC_BIT_PORT0_SEL = 0;
    localparam logic [7:0] DRC_DUAL_RX_RESET = 8'h01;
    localparam logic [7:0] DRC_DUAL_RX_WMASK = 8'h7B;
    // Equalizer test fields
    localparam int DRC_BIT_EQ_RESTART = 6;
    localparam int DRC_BIT_EQ_FLOOR_EN = 5;
    localparam int DRC_BIT_EQ_FLOOR_START = 4;
    localparam logic [7:0] DRC_EQ_TEST_RESET = 8'h00;
    localparam logic [7:0] DRC_EQ_TEST_WMASK = 8'h70;
    // Lane mode encodings
    localparam logic [1:0] DRC_LANE_AUTO = 2'h0;
    localparam logic [1:0] DRC_LANE_TWO = 2'h1;
    localparam logic [1:0] DRC_LANE_ONE_PRI = 2'h2;
    localparam logic [1:0] DRC_LANE_ONE_SEC = 2'h3;
endpackage : drc_pkg

// ===== verilog/drc_sync2.sv
// Two flip-flop synchroniser for pin levels
`timescale 1ns/1ps
`default_nettype none
module drc_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } drc_sync_st_t;
    drc_sync_st_t state_reg;
    drc_sync_st_t state_next;

    // First stage feeds only the second stage
    always_comb begin
        state_next.meta = i_async;
        state_next.sync = state_reg.meta;
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign o_sync = state_reg.sync;
endmodule : drc_sync2
`default_nettype wire

// ===== verilog/drc_eq_ctl.sv
// Per-port equalizer start control: restart pulse and start level choice
`timescale 1ns/1ps
`default_nettype none
module drc_eq_ctl (
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic i_restart_level,
    input wire logic i_floor_enable,
    input wire logic i_floor_start,
    output logic o_restart_pulse,
    output logic o_start_from_floor
);
    typedef struct packed {
        logic restart_prev;
        logic restart_pulse;
        logic from_floor;
    } drc_eq_st_t;
    drc_eq_st_t state_reg;
    drc_eq_st_t state_next;

    // Rising edge of the held restart level starts one adaptation run
    always_comb begin
        state_next.restart_prev = i_restart_level;
        state_next.restart_pulse = i_restart_level & ~state_reg.restart_prev;
        // Floor start only counts while its enable is set
        state_next.from_floor = i_floor_enable & i_floor_start;
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign o_restart_pulse = state_reg.restart_pulse;
    assign o_start_from_floor = state_reg.from_floor;
endmodule : drc_eq_ctl
`default_nettype wire

// ===== verif/drc_ser_model.sv
// Far-side model: remote serializer link status and filtered back channel
`timescale 1ns/1ps
`default_nettype none
module drc_ser_model (
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic [2:0] i_cmd,
    output logic o_linked,
    output logic o_video_off,
    output logic o_dual,
    output logic o_bc_filtered
);
    // Status lands one cycle after the command; filtered source toggles so a stale value shows
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_linked <= 1'h0;
            o_video_off <= 1'h0;
            o_dual <= 1'h0;
            o_bc_filtered <= 1'h0;
        end else begin
            o_linked <= i_cmd[0];
            o_video_off <= i_cmd[1];
            o_dual <= i_cmd[2];
            o_bc_filtered <= ~o_bc_filtered;
        end
    end
endmodule : drc_ser_model
`default_nettype wire

// ===== verif/drc_regs_chk.sv
// Assertion checker for the dual receive control bank
`timescale 1ns/1ps
`default_nettype none
module drc_regs_chk
    import drc_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic [7:0] o_reg_rdata,
    input wire logic o_reg_rvalid,
    input wire logic i_linked,
    input wire logic i_remote_video_disabled,
    input wire logic i_remote_dual_link,
    input wire logic i_backchannel_gpio_input,
    input wire logic i_backchannel_gpio_filtered,
    input wire logic o_backchannel_gpio,
    input wire logic o_rx_lock,
    input wire logic [1:0] o_serial_input_lane_mode,
    input wire logic o_dual_link_status,
    input wire logic o_port0_access,
    input wire logic o_port1_access,
    input wire logic [1:0] o_eq_restart,
    input wire logic [1:0] o_eq_start_from_floor
);
    logic [7:0] sh, eq0, eq1, rexp;
    logic up;
    wire logic rq = eq0[6] | eq1[6];
    // Shadow bank, steered as the host sees it; up masks the first edge after reset
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            sh <= DRC_DUAL_RX_RESET;
            eq0 <= 8'h00;
            eq1 <= 8'h00;
            up <= 1'h0;
        end else begin
            up <= 1'h1;
            if (i_reg_wr && i_reg_addr == 8'h34) sh <= i_reg_wdata & 8'h7B;
            if (i_reg_wr && i_reg_addr == 8'h35 && sh[1]) eq1 <= i_reg_wdata & 8'h70;
            if (i_reg_wr && i_reg_addr == 8'h35 && sh[0]) eq0 <= i_reg_wdata & 8'h70;
        end
    end
    // Expected read data for the address on the bus
    always_comb begin
        rexp = 8'h00;
        if (i_reg_addr == 8'h34) rexp = sh;
        if (i_reg_addr == 8'h35) rexp = sh[1] ? eq1 : (sh[0] ? eq0 : 8'h00);
    end
    default clocking dc @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);
    sequence restart_seen;
        $rose(rq);
    endsequence
    sequence pulse_both;
        o_eq_restart == 2'h3 ##1 o_eq_restart == 2'h0;
    endsequence
    lock_follow_a: assert property (up |->
        o_rx_lock == $past(i_linked && (sh[6] || !i_remote_video_disabled))) else $error("lock level wrong");
    raw_gpio_a: assert property (up && sh[5] && $past(sh[5], 3) |->
        o_backchannel_gpio == $past(i_backchannel_gpio_input, 3)) else $error("raw back channel wrong");
    filt_gpio_a: assert property (up && !sh[5] && !$past(sh[5]) |->
        o_backchannel_gpio == $past(i_backchannel_gpio_filtered)) else $error("filtered back channel wrong");
    lane_mode_a: assert property (up |-> o_serial_input_lane_mode == sh[4:3])
        else $error("lane mode wrong");
    port_sel_a: assert property ({o_port1_access, o_port0_access} == sh[1:0])
        else $error("port access wrong");
    dual_link_a: assert property (up |-> o_dual_link_status == $past(i_remote_dual_link))
        else $error("dual link status wrong");
    read_valid_a: assert property (up |-> o_reg_rvalid == $past(i_reg_rd))
        else $error("read valid wrong");
    read_data_a: assert property (i_reg_rd |=> o_reg_rdata == $past(rexp))
        else $error("read data wrong");
    restart_both_a: assert property (restart_seen |=> pulse_both)
        else $error("restart pulse missing");
    restart_quiet_a: assert property (!$rose(rq) |=> o_eq_restart == 2'h0)
        else $error("restart pulse spurious");
    floor_start_a: assert property (up |->
        o_eq_start_from_floor == $past({eq1[5] & eq1[4], eq0[5] & eq0[4]})) else $error("floor start wrong");
endmodule : drc_regs_chk
bind drc_regs drc_regs_chk chk_u (.*);
`default_nettype wire

// ===== verif/tb_drc_regs.sv
// Testbench: register access sequences against the dual receive control bank
`timescale 1ns/1ps
`default_nettype none
module tb_drc_regs
    import drc_pkg::*;
;
    logic i_mclk = 1'h0, i_rstn = 1'h0, i_reg_wr = 1'h0, i_reg_rd = 1'h0, i_backchannel_gpio_input = 1'h0;
    logic [7:0] i_reg_addr = 8'h00, i_reg_wdata = 8'h00, o_reg_rdata;
    logic [2:0] cmd = 3'h0;
    logic [1:0] o_serial_input_lane_mode, o_eq_restart, o_eq_start_from_floor;
    logic i_linked, i_remote_video_disabled, i_remote_dual_link, i_backchannel_gpio_filtered;
    logic o_reg_rvalid, o_backchannel_gpio, o_rx_lock, o_dual_link_status, o_port0_access, o_port1_access;
    int n_errors = 0, comparisons = 0, cycles = 0;
    always #25 i_mclk = ~i_mclk;
    drc_regs dut_u (.*);
    drc_ser_model far_u (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_cmd(cmd), .o_linked(i_linked),
        .o_video_off(i_remote_video_disabled), .o_dual(i_remote_dual_link), .o_bc_filtered(i_backchannel_gpio_filtered));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Strobes rise after a falling edge and drop only after the taking edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_mclk);
        i_reg_wr = 1'h1;
        i_reg_addr = a;
        i_reg_wdata = d;
        @(negedge i_mclk);
        i_reg_wr = 1'h0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge i_mclk);
        i_reg_rd = 1'h1;
        i_reg_addr = a;
        @(negedge i_mclk);
        i_reg_rd = 1'h0;
        chk({7'h0, o_reg_rvalid}, 8'h01);
        chk(o_reg_rdata, exp);
    endtask : rd
    task automatic wait_n(input int n);
        repeat (n) @(negedge i_mclk);
    endtask : wait_n
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : complete_run
    // Hang guard: the sequence needs well under a thousand cycles
    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            complete_run();
        end
    end
    initial begin
        wait_n(4);
        i_rstn = 1'h1;
        rd(8'h34, 8'h01);
        rd(8'h35, 8'h00);
        rd(8'h36, 8'h00);
        wr(8'h36, 8'h7B);
        rd(8'h34, 8'h01);
        $display("test reset values done");
        for (int m = 0; m < 4; m++) begin
            wr(8'h34, 8'h85 | {3'h0, m[1:0], 3'h0});
            chk({6'h0, o_serial_input_lane_mode}, {6'h0, m[1:0]});
            rd(8'h34, 8'h01 | {3'h0, m[1:0], 3'h0});
        end
        $display("test lane modes done");
        for (int i = 0; i < 8; i++) begin
            wr(8'h34, {1'h0, i[2], 6'h01});
            cmd = {1'h0, i[1], i[0]};
            wait_n(3);
            chk({7'h0, o_rx_lock}, {7'h0, i[0] & (i[2] | ~i[1])});
        end
        chk({7'h0, o_dual_link_status}, 8'h00);
        cmd = 3'h4;
        wait_n(3);
        chk({7'h0, o_dual_link_status}, 8'h01);
        $display("test lock and link done");
        wr(8'h34, 8'h21);
        for (int i = 0; i < 4; i++) begin
            i_backchannel_gpio_input = i[0];
            wait_n(4);
            chk({7'h0, o_backchannel_gpio}, {7'h0, i[0]});
        end
        wr(8'h34, 8'h01);
        wait_n(2);
        chk({7'h0, o_backchannel_gpio}, {7'h0, ~i_backchannel_gpio_filtered});
        $display("test back channel done");
        wr(8'h34, 8'h03);
        chk({6'h0, o_port1_access, o_port0_access}, 8'h03);
        wr(8'h35, 8'h3F);
        wait_n(1);
        chk({6'h0, o_eq_start_from_floor}, 8'h03);
        rd(8'h35, 8'h30);
        wr(8'h34, 8'h02);
        wr(8'h35, 8'h20);
        wait_n(1);
        chk({6'h0, o_eq_start_from_floor}, 8'h01);
        rd(8'h35, 8'h20);
        wr(8'h34, 8'h01);
        rd(8'h35, 8'h30);
        wr(8'h35, 8'h10);
        wait_n(1);
        chk({6'h0, o_eq_start_from_floor}, 8'h00);
        $display("test port steering done");
        wr(8'h34, 8'h02);
        wr(8'h35, 8'h40);
        wait_n(1);
        chk({6'h0, o_eq_restart}, 8'h03);
        wait_n(1);
        chk({6'h0, o_eq_restart}, 8'h00);
        rd(8'h35, 8'h40);
        wr(8'h35, 8'h00);
        $display("test restart done");
        i_rstn = 1'h0;
        wait_n(4);
        i_rstn = 1'h1;
        rd(8'h34, 8'h01);
        rd(8'h35, 8'h00);
        $display("test second reset done");
        complete_run();
    end
endmodule : tb_drc_regs
`default_nettype wire
